// ### rate_readback_pkg.sv
// Purpose: shared constants and types for the data rate readback block
// Assumes: 8-bit registers on a two-wire serial slave, subaddresses 0..7
// Notes: field positions are bit indices inside the 8-bit registers
`default_nettype none
package rate_readback_pkg;
   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int COUNT_W = 23;
   localparam int WIN_W = 18;
   localparam int BASE_EXP = 14;
   localparam int CNT_HI_W = 7;
   localparam int COARSE_W = 9;

   // ---------------------------------------------------------------
   // subaddress map
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_CNT_HI = 3'h0;
   localparam logic [2:0] ADDR_CNT_MID = 3'h1;
   localparam logic [2:0] ADDR_CNT_LO = 3'h2;
   localparam logic [2:0] ADDR_COARSE = 3'h3;
   localparam logic [2:0] ADDR_MISC = 3'h4;
   localparam logic [2:0] ADDR_CTRL_A = 3'h5;
   localparam logic [2:0] ADDR_CTRL_B = 3'h6;
   localparam logic [2:0] ADDR_CTRL_C = 3'h7;
   localparam logic [7:0] SUB_LAST = 8'h07;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int A_LOCK_REF = 0;
   localparam int A_FINE_EN = 1;
   localparam int A_RATIO_LO = 2;
   localparam int A_RANGE_LO = 6;
   localparam int B_MEAS_RST = 3;
   localparam int B_ACQ_RST = 5;
   localparam int C_LOS_INV = 2;
   localparam int MISC_COARSE_LSB = 0;
   localparam int MISC_LOCK_LOST = 1;
   localparam int MISC_DONE = 2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [6:0] DEV_ADDR_DEF = 7'h40;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [2:0] addr;
      logic [7:0] data;
   } reg_wr_t;
endpackage
`default_nettype wire

// ### serial_reg_slave.sv
// Purpose: two-wire serial slave giving byte access to eight registers
// Assumes: scl and sda arrive asynchronously; sda is open drain
// Notes: subaddress auto-increments and sticks at the highest one
`default_nettype none
module serial_reg_slave import rate_readback_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic [2:0] rd_addr_o,
   input wire logic [7:0] rd_data_i,
   output reg_wr_t wr_o
);
   typedef enum {st_idle, st_addr, st_sub, st_write, st_read} i2c_state_t;

   i2c_state_t st_q, st_d;
   logic [1:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic [2:0] ptr_q, ptr_d;
   logic oe_n_q, oe_n_d, nack_q, nack_d;
   reg_wr_t wr_q, wr_d;
   logic scl_f, sda_f, scl_rise, scl_fall, start, stop;

   function automatic logic [2:0] inc_ptr(input logic [2:0] p);
      inc_ptr = (p == SUB_LAST[2:0]) ? p : p + 3'h1;
   endfunction

   assign scl_f = filt_q[1];
   assign sda_f = filt_q[0];
   assign scl_rise = scl_f & ~prev_q[1];
   assign scl_fall = ~scl_f & prev_q[1];
   assign start = scl_f & prev_q[1] & prev_q[0] & ~sda_f;
   assign stop = scl_f & prev_q[1] & ~prev_q[0] & sda_f;
   assign rd_addr_o = ptr_q;
   assign sda_oe_n_o = oe_n_q;
   assign wr_o = wr_q;

   always_comb begin
      filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      oe_n_d = oe_n_q;
      nack_d = nack_q;
      wr_d = '0;
      if (start) begin
         st_d = st_addr;
         cnt_d = 4'h0;
         oe_n_d = 1'b1;
      end else if (stop) begin
         st_d = st_idle;
         oe_n_d = 1'b1;
      end else if (st_q != st_idle && scl_rise) begin
         if (cnt_q < 4'h8) begin
            cnt_d = cnt_q + 4'h1;
            if (st_q != st_read) begin
               sh_d = {sh_q[6:0], sda_f};
            end
         end else if (cnt_q == 4'h9 && st_q == st_read) begin
            nack_d = sda_f;
         end
      end else if (st_q != st_idle && scl_fall) begin
         if (cnt_q < 4'h8) begin
            if (st_q == st_read && cnt_q != 4'h0) begin
               sh_d = {sh_q[6:0], 1'b0};
               oe_n_d = sh_q[6];
            end
         end else if (cnt_q == 4'h8) begin
            cnt_d = 4'h9;
            case (st_q)
               st_addr: begin
                  if (sh_q[7:1] == DEV_ADDR) begin
                     oe_n_d = 1'b0;
                  end else begin
                     st_d = st_idle;
                  end
               end
               st_sub: begin
                  if (sh_q <= SUB_LAST) begin
                     oe_n_d = 1'b0;
                     ptr_d = sh_q[2:0];
                  end else begin
                     st_d = st_idle;
                  end
               end
               st_write: begin
                  oe_n_d = 1'b0;
                  wr_d = '{en: 1'b1, addr: ptr_q, data: sh_q};
               end
               st_read: begin
                  oe_n_d = 1'b1;
                  ptr_d = inc_ptr(ptr_q);
               end
               default: st_d = st_idle;
            endcase
         end else begin
            cnt_d = 4'h0;
            oe_n_d = 1'b1;
            case (st_q)
               st_addr: begin
                  if (sh_q[0]) begin
                     st_d = st_read;
                     sh_d = rd_data_i;
                     oe_n_d = rd_data_i[7];
                  end else begin
                     st_d = st_sub;
                  end
               end
               st_sub: st_d = st_write;
               st_write: ptr_d = inc_ptr(ptr_q);
               st_read: begin
                  if (nack_q) begin
                     st_d = st_idle;
                  end else begin
                     sh_d = rd_data_i;
                     oe_n_d = rd_data_i[7];
                  end
               end
               default: st_d = st_idle;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s1_q <= 2'h3;
         s2_q <= 2'h3;
         s3_q <= 2'h3;
         filt_q <= 2'h3;
         prev_q <= 2'h3;
         st_q <= st_idle;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 3'h0;
         oe_n_q <= 1'b1;
         nack_q <= 1'b1;
         wr_q <= '0;
         sda_o <= 1'b0;
      end else if (ce_i) begin
         s1_q <= {scl_i, sda_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
         prev_q <= filt_q;
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         oe_n_q <= oe_n_d;
         nack_q <= nack_d;
         wr_q <= wr_d;
         sda_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### data_rate_readback_control.sv
// Purpose: control registers, fine rate measurement and coarse readback
// Assumes: rate_tick_i is a same-clock strobe per recovered data event
// Notes: pin inputs pass three flops; a change counts when 2nd and 3rd agree
`default_nettype none
module data_rate_readback_control import rate_readback_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic lock_lost_i,
   input wire logic signal_lost_i,
   input wire logic ref_clock_in_i,
   input wire logic rate_tick_i,
   input wire logic [COARSE_W-1:0] coarse_code_i,
   output logic signal_lost_o,
   output logic acq_restart_o,
   output logic lock_to_ref_o,
   output logic [3:0] ref_ratio_o,
   output logic fine_meas_en_o
);
   typedef enum {ms_idle, ms_run, ms_done} meas_state_t;

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   reg_wr_t wr;
   logic [2:0] rd_addr;
   logic [7:0] rd_data;

   serial_reg_slave #(
      .DEV_ADDR(DEV_ADDR)
   ) u_slave (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .wr_o(wr)
   );

   // ---------------------------------------------------------------
   // pin synchronisers: {lock_lost, signal_lost, ref_clock_in}
   // ---------------------------------------------------------------
   logic [2:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   logic ref_prev_q, ref_rise, lock_f, sig_f;

   assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
   assign lock_f = filt_q[2];
   assign sig_f = filt_q[1];
   assign ref_rise = filt_q[0] & ~ref_prev_q;

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   logic [7:0] control_reg_a_q, control_reg_a_d, control_reg_b_q, control_reg_b_d, control_reg_c_q, control_reg_c_d;
   logic [COARSE_W-1:0] coarse_q;
   logic los_q, los_d, acq_q, acq_d;
   logic wr_b, meas_clr, meas_go, fine_on, start;

   function automatic logic [WIN_W-1:0] win_len(input logic [1:0] sel);
      win_len = WIN_W'(1) << (BASE_EXP + int'(sel));
   endfunction

   assign wr_b = wr.en && wr.addr == ADDR_CTRL_B;
   assign meas_clr = wr_b && wr.data[B_MEAS_RST];
   assign meas_go = wr_b && !wr.data[B_MEAS_RST] && control_reg_b_q[B_MEAS_RST];
   assign fine_on = wr.en && wr.addr == ADDR_CTRL_A &&
                    wr.data[A_FINE_EN] && !control_reg_a_q[A_FINE_EN];
   assign start = (meas_go || fine_on) && control_reg_a_d[A_FINE_EN];

   always_comb begin
      control_reg_a_d = control_reg_a_q;
      control_reg_b_d = control_reg_b_q;
      control_reg_c_d = control_reg_c_q;
      if (wr.en) begin
         case (wr.addr)
            ADDR_CTRL_A: control_reg_a_d = wr.data;
            ADDR_CTRL_B: control_reg_b_d = wr.data;
            ADDR_CTRL_C: control_reg_c_d = wr.data;
            default: ;
         endcase
      end
      // polarity select of the loss output
      los_d = sig_f ^ control_reg_c_q[C_LOS_INV];
      // pulse only; control registers are left untouched
      acq_d = wr_b && !wr.data[B_ACQ_RST] && control_reg_b_q[B_ACQ_RST];
   end

   // ---------------------------------------------------------------
   // fine measurement
   // ---------------------------------------------------------------
   meas_state_t ms_q, ms_d;
   logic [WIN_W-1:0] win_q, win_d, refc_q, refc_d;
   logic [COUNT_W-1:0] acc_q, acc_d, res_q, res_d;
   logic done_q, done_d, finish;

   always_comb begin
      ms_d = ms_q;
      win_d = win_q;
      refc_d = refc_q;
      acc_d = acc_q;
      res_d = res_q;
      finish = 1'b0;
      case (ms_q)
         ms_idle: ;
         ms_run: begin
            if (rate_tick_i && acc_q != '1) begin
               acc_d = acc_q + 1'b1;
            end
            if (ref_rise) begin
               refc_d = refc_q + 1'b1;
               finish = (refc_d == win_q);
            end
         end
         ms_done: ;
         default: ms_d = ms_idle;
      endcase
      if (finish) begin
         res_d = acc_d;
         ms_d = ms_done;
      end
      if (start) begin
         ms_d = ms_run;
         refc_d = '0;
         acc_d = '0;
         win_d = win_len(control_reg_a_d[A_RANGE_LO +: 2]);
      end else if (meas_clr || !control_reg_a_q[A_FINE_EN]) begin
         ms_d = ms_idle;
      end
      // completion wins over a clear in the same cycle
      if (finish) begin
         done_d = 1'b1;
      end else if (meas_clr || start) begin
         done_d = 1'b0;
      end else begin
         done_d = done_q;
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_data = 8'h00;
      case (rd_addr)
         ADDR_CNT_HI: rd_data = {1'b0, res_q[COUNT_W-1 -: CNT_HI_W]};
         ADDR_CNT_MID: rd_data = res_q[15:8];
         ADDR_CNT_LO: rd_data = res_q[7:0];
         ADDR_COARSE: rd_data = coarse_q[COARSE_W-1:1];
         ADDR_MISC: begin
            rd_data[MISC_COARSE_LSB] = coarse_q[0];
            rd_data[MISC_LOCK_LOST] = lock_f;
            rd_data[MISC_DONE] = done_q;
         end
         ADDR_CTRL_A: rd_data = control_reg_a_q;
         ADDR_CTRL_B: rd_data = control_reg_b_q;
         ADDR_CTRL_C: rd_data = control_reg_c_q;
         default: rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
         filt_q <= 3'h0;
         ref_prev_q <= 1'b0;
         control_reg_a_q <= CTRL_RESET;
         control_reg_b_q <= CTRL_RESET;
         control_reg_c_q <= CTRL_RESET;
         coarse_q <= '0;
         los_q <= 1'b0;
         acq_q <= 1'b0;
         ms_q <= ms_idle;
         win_q <= '0;
         refc_q <= '0;
         acc_q <= '0;
         res_q <= '0;
         done_q <= 1'b0;
      end else if (ce_i) begin
         s1_q <= {lock_lost_i, signal_lost_i, ref_clock_in_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         filt_q <= filt_d;
         ref_prev_q <= filt_q[0];
         control_reg_a_q <= control_reg_a_d;
         control_reg_b_q <= control_reg_b_d;
         control_reg_c_q <= control_reg_c_d;
         coarse_q <= coarse_code_i;
         los_q <= los_d;
         acq_q <= acq_d;
         ms_q <= ms_d;
         win_q <= win_d;
         refc_q <= refc_d;
         acc_q <= acc_d;
         res_q <= res_d;
         done_q <= done_d;
      end
   end

   assign signal_lost_o = los_q;
   assign acq_restart_o = acq_q;
   assign lock_to_ref_o = control_reg_a_q[A_LOCK_REF];
   assign ref_ratio_o = control_reg_a_q[A_RATIO_LO +: 4];
   assign fine_meas_en_o = control_reg_a_q[A_FINE_EN];

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   count_split_a: assert property (
      rd_addr == ADDR_CNT_HI |-> rd_data == {1'b0, res_q[22:16]})
      else $error("high count byte mismatch");
   range_win_a: assert property (
      ce_i && start |=> win_q == WIN_W'(1) << (14 + int'(control_reg_a_q[7:6])))
      else $error("window not set from range field");
   fine_level_a: assert property (
      ce_i && !control_reg_a_q[A_FINE_EN] && !start |=> ms_q == ms_idle)
      else $error("measuring without enable");
   restart_clr_a: assert property (
      ce_i && meas_clr |=> ms_q == ms_idle && (!done_q || $past(finish)))
      else $error("restart did not clear done");
   coarse_code_a: assert property (
      rd_addr == ADDR_MISC |-> rd_data[0] == coarse_q[0])
      else $error("coarse lsb missing");
   los_high_a: assert property (
      ce_i && !control_reg_c_q[C_LOS_INV] && sig_f |=> signal_lost_o)
      else $error("loss output not high");
   los_low_a: assert property (
      ce_i && control_reg_c_q[C_LOS_INV] && sig_f |=> !signal_lost_o)
      else $error("loss output not low");
   acq_pulse_a: assert property (
      ce_i && acq_d |=> acq_restart_o ##1 (!acq_restart_o || !$past(ce_i)))
      else $error("acquisition restart not one pulse");
   keep_ctrl_a: assert property (
      ce_i && acq_d |=> control_reg_a_q == $past(control_reg_a_q) &&
                        control_reg_c_q == $past(control_reg_c_q))
      else $error("acquisition restart changed controls");
   done_seen_a: assert property (
      ce_i && finish && !start && !meas_clr |=> done_q ##0
      (rd_addr != ADDR_MISC || rd_data[MISC_DONE]))
      else $error("completion not flagged");
   hold_count_a: assert property (
      done_q && $past(done_q) |-> $stable(res_q))
      else $error("count moved while complete");

   meas_done_c: cover property (ms_q == ms_run ##1 ms_q == ms_done);
   acq_seen_c: cover property (acq_restart_o);
   clr_done_c: cover property (done_q ##1 meas_clr);
endmodule
`default_nettype wire

// ### i2c_host_model.sv
// Purpose: host controller model on the two-wire register bus
// Assumes: data line is open drain, resolved by the bench with a pull-up
// Notes: half sets each scl and sda step in clocks, an scl phase is two steps; raise it for a slow host
`default_nettype none
module i2c_host_model import rate_readback_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
   parameter int REF_MHZ = 50
) (
   input wire logic core_clk_i,
   input wire logic sda_line_i,
   output var logic scl_o,
   output var logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int half = 5;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // ---------------------------------------------------------------
   // bit level
   // ---------------------------------------------------------------
   task automatic sc(input logic b);
      repeat (half) @(posedge core_clk_i);
      scl_o <= b;
   endtask

   task automatic sd(input logic b);
      repeat (half) @(posedge core_clk_i);
      sda_o <= b;
   endtask

   task automatic bitx(input logic d, output logic r);
      sc(1'b0);
      sd(d);
      sc(1'b1);
      repeat (half) @(posedge core_clk_i);
      r = sda_line_i;
   endtask

   task automatic start();
      sc(1'b0);
      sd(1'b1);
      sc(1'b1);
      sd(1'b0);
      sc(1'b0);
   endtask

   task automatic stop();
      sc(1'b0);
      sd(1'b0);
      sc(1'b1);
      sd(1'b1);
   endtask

   task automatic xfer(input logic [7:0] d, input logic ack_in,
                       output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
      bitx(ack_in, ack);
   endtask

   // ---------------------------------------------------------------
   // register access
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] sub, input logic [7:0] d,
                     output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, r, a0);
      xfer(sub, 1'b1, r, a1);
      xfer(d, 1'b1, r, a2);
      stop();
      ok = ~(a0 | a1 | a2);
   endtask

   task automatic rd(input logic [7:0] sub, input int n,
                     output logic [23:0] v);
      logic [7:0] r;
      logic a;
      v = '0;
      start();
      xfer({DEV_ADDR, 1'b0}, 1'b1, r, a);
      xfer(sub, 1'b1, r, a);
      start();
      xfer({DEV_ADDR, 1'b1}, 1'b1, r, a);
      for (int i = 1; i <= n; i++) begin
         xfer(8'hFF, i == n, r, a);
         v = {v[15:0], r};
      end
      stop();
   endtask

   // ---------------------------------------------------------------
   // fine rate readback
   // ---------------------------------------------------------------
   task automatic collect(input logic [1:0] rng, output logic [22:0] cnt,
                          output int rate, output logic ok);
      logic [23:0] m, v;
      rd(8'(ADDR_MISC), 1, m);
      rd(8'(ADDR_CNT_HI), 3, v);
      cnt = v[22:0];
      rate = (int'(cnt) * REF_MHZ) >>> (BASE_EXP + int'(rng));
      ok = m[MISC_DONE] & ~m[MISC_LOCK_LOST];
   endtask

   task automatic fine_read(input logic [1:0] rng, output logic [22:0] cnt,
                            output int rate, output logic ok);
      logic [23:0] m;
      logic a;
      wr(8'(ADDR_CTRL_A), {rng, 4'h0, 2'b10}, a);
      wr(8'(ADDR_CTRL_B), 8'h08, a);
      wr(8'(ADDR_CTRL_B), 8'h00, a);
      m = '0;
      for (int i = 0; i < 200 && m[MISC_DONE] !== 1'b1; i++) begin
         rd(8'(ADDR_MISC), 1, m);
      end
      collect(rng, cnt, rate, ok);
   endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: self-checking bench for the data rate readback block
// Assumes: pull-up on the data line; reference pin 3 high, 2 low clocks
// Notes: one rate event per clock while the reference runs
`default_nettype none
module tb_top import rate_readback_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REF_PER = 5;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic lock_lost = 1'b0;
   logic signal_lost = 1'b0;
   logic ref_run = 1'b0;
   logic ref_pin = 1'b0;
   logic [2:0] ref_ph = 3'h0;
   logic [COARSE_W-1:0] coarse = '0;
   logic scl, sda_h, sda_d, sda_oe_n, los_o, acq, l2r, fine_en, ok;
   logic [3:0] ratio;
   logic [22:0] cnt;
   logic [23:0] v;
   int rate;
   int n_fail = 0;
   int samples_checked = 0;
   int n_acq = 0;
   wire logic sda_line = sda_h & (sda_oe_n | sda_d);

   always #2 clk = ~clk;

   always @(posedge clk) begin
      ref_ph <= (ref_ph == 3'(REF_PER - 1)) ? 3'h0 : ref_ph + 3'h1;
      ref_pin <= ref_run & (ref_ph < 3'h3);
      if (acq) n_acq <= n_acq + 1;
   end

   data_rate_readback_control dut_u (
      .core_clk_i(clk), .reset_i(rst), .ce_i(ce), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n),
      .lock_lost_i(lock_lost), .signal_lost_i(signal_lost), .ref_clock_in_i(ref_pin),
      .rate_tick_i(ref_run), .coarse_code_i(coarse),
      .signal_lost_o(los_o), .acq_restart_o(acq), .lock_to_ref_o(l2r),
      .ref_ratio_o(ratio), .fine_meas_en_o(fine_en)
   );

   i2c_host_model #(.REF_MHZ(50)) host_u (
      .core_clk_i(clk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_h)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s", $time, msg);
         n_fail++;
      end
   endtask

   task automatic wrc(input logic [2:0] sub, input logic [7:0] d);
      host_u.wr(8'(sub), d, ok);
      chk(ok, 1'b1, "write not acked");
   endtask

   task automatic print_verdict();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      host_u.rd(8'(ADDR_CTRL_A), 3, v);
      chk(v, {3{CTRL_RESET}}, "control reset values");
      chk({l2r, ratio, fine_en, los_o, acq}, 8'h00, "outputs at reset");
      host_u.rd(8'(ADDR_MISC), 1, v);
      chk(v[MISC_DONE], 1'b0, "done at reset");
   endtask

   task automatic t_coarse();
      logic [COARSE_W-1:0] codes [2];
      codes = '{9'h1A5, 9'h05A};
      foreach (codes[i]) begin
         coarse <= codes[i];
         wt(4);
         host_u.rd(8'(ADDR_COARSE), 2, v);
         chk({v[15:8], v[MISC_COARSE_LSB]}, codes[i], "coarse code");
      end
   endtask

   task automatic t_los();
      signal_lost <= 1'b1;
      wt(10);
      chk(los_o, 1'b1, "loss active high");
      wrc(ADDR_CTRL_C, 8'h04);
      chk(los_o, 1'b0, "loss active low");
      signal_lost <= 1'b0;
      wt(10);
      chk(los_o, 1'b1, "no loss, inverted");
      wrc(ADDR_CTRL_C, 8'h00);
      chk(los_o, 1'b0, "no loss, default");
      wrc(ADDR_CTRL_C, 8'h04);
      ce <= 1'b0;
      signal_lost <= 1'b1;
      wt(10);
      chk(los_o, 1'b1, "output moved while frozen");
      ce <= 1'b1;
      wt(10);
      chk(los_o, 1'b0, "loss after enable");
      signal_lost <= 1'b0;
   endtask

   task automatic t_acq();
      wrc(ADDR_CTRL_A, 8'h55);
      wrc(ADDR_CTRL_B, 8'h20);
      chk(n_acq, 0, "restart on set");
      wrc(ADDR_CTRL_B, 8'h00);
      chk(n_acq, 1, "restart pulse count");
      host_u.rd(8'(ADDR_CTRL_A), 3, v);
      chk(v, 24'h550004, "controls after restart");
      chk({l2r, ratio, fine_en}, 6'b1_0101_0, "mode outputs");
      host_u.wr(8'h08, 8'h00, ok);
      chk(ok, 1'b0, "unmapped subaddress acked");
      wrc(ADDR_CNT_LO, 8'hFF);
      host_u.rd(8'(ADDR_CNT_LO), 1, v);
      chk(v[7:0], 8'h00, "read-only count written");
   endtask

   task automatic t_fine();
      int d;
      ref_run <= 1'b1;
      wrc(ADDR_CTRL_A, 8'h42);
      host_u.fine_read(2'h0, cnt, rate, ok);
      chk(ok, 1'b1, "measurement not done");
      d = int'(cnt) - (REF_PER << BASE_EXP);
      chk(d >= -6 && d <= 6, 1'b1, "fine count");
      chk(rate >= 249 && rate <= 250, 1'b1, "data rate");
      host_u.rd(8'(ADDR_CNT_HI), 3, v);
      chk(v, {1'b0, cnt}, "count not held");
      chk(fine_en, 1'b1, "fine enable dropped");
      lock_lost <= 1'b1;
      wt(10);
      host_u.collect(2'h0, cnt, rate, ok);
      chk(ok, 1'b0, "readback valid while lock lost");
      lock_lost <= 1'b0;
      wrc(ADDR_CTRL_B, 8'h08);
      wrc(ADDR_CTRL_B, 8'h00);
      host_u.rd(8'(ADDR_MISC), 1, v);
      chk(v[MISC_DONE], 1'b0, "done after restart");
      chk(fine_en, 1'b1, "fine enable after restart");
   endtask

   initial begin
      wt(10);
      rst <= 1'b0;
      wt(10);
      t_reset();
      t_coarse();
      t_los();
      t_acq();
      t_fine();
      print_verdict();
   end
endmodule
`default_nettype wire
